// file: hw/bst_pkg.sv
// Shared constants and types for the boundary-scan port and its test controller.
// Function
// - Unused port: test clock low, output open
// - Inputs sampled rising, output changed falling
// - Floating mode-select and data-in read high
// - Instruction selects exactly one serial register
// - Data enters MSB, LSB drives output
// - Output driven only in shift states
// - Five mode-select highs reach reset state
// - Port reset leaves memory operation alone
// - Self reset at power-up, output floated
// - Three-bit instruction register loaded serially
// - Identification instruction after power-up and reset
// - Capture-instruction loads 01 into low bits
// - One-bit bypass, cleared when bypass executes
// - Boundary register: one cell per pin
// - Capture latches pins, shift connects boundary register
// - Three instructions capture the pin ring
// - Identification code captured then shifted out
// - Controller loads any instruction code; reserved codes select bypass
// - New instruction takes effect at update-instruction
// - Floated-sample instruction floats read-data bus
// - Cell 47 enables read-data drivers under external-test
package bst_pkg;

	typedef enum logic [3:0] {
		BST_EXIT2_DR  = 4'h0,
		BST_EXIT1_DR  = 4'h1,
		BST_SHIFT_DR  = 4'h2,
		BST_PAUSE_DR  = 4'h3,
		BST_SEL_IR    = 4'h4,
		BST_UPDATE_DR = 4'h5,
		BST_CAPT_DR   = 4'h6,
		BST_SEL_DR    = 4'h7,
		BST_EXIT2_IR  = 4'h8,
		BST_EXIT1_IR  = 4'h9,
		BST_SHIFT_IR  = 4'ha,
		BST_PAUSE_IR  = 4'hb,
		BST_IDLE      = 4'hc,
		BST_UPDATE_IR = 4'hd,
		BST_CAPT_IR   = 4'he,
		BST_RESET     = 4'hf
	} bst_state_e;

	localparam int         IR_W        = 3;
	localparam int         ID_W        = 32;
	localparam int         BSR_W       = 64;
	localparam int         OE_CELL     = 47;
	localparam logic [2:0] IR_CAPTURE  = 3'h1;
	localparam logic [2:0] INS_EXTEST  = 3'h0;
	localparam logic [2:0] INS_IDCODE  = 3'h1;
	localparam logic [2:0] INS_SAMPLEZ = 3'h2;
	localparam logic [2:0] INS_SAMPLE  = 3'h4;
	localparam logic [2:0] INS_BYPASS  = 3'h7;
	// Arbitrary neutral identification value; bit 0 is one as the scan protocol expects.
	localparam logic [31:0] ID_DEFAULT = 32'h0a5a_5001;

	// Test clock half period: a least time, so rounded up to whole system cycles.
	localparam int SYS_PERIOD_NS = 8;
	localparam int TCK_HALF_NS   = 40;
	localparam int TCK_HALF_CYC  = (TCK_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

	// Mode-select header sequences from run-test/idle, first bit in bit 0.
	localparam logic [5:0] HDR_RESET   = 6'h1f;
	localparam logic [2:0] HDR_RST_LEN = 3'h6;
	localparam logic [5:0] HDR_IR      = 6'h03;
	localparam logic [2:0] HDR_IR_LEN  = 3'h4;
	localparam logic [5:0] HDR_DR      = 6'h01;
	localparam logic [2:0] HDR_DR_LEN  = 3'h3;

	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_TXD    = 12'h004;
	localparam logic [11:0] OFS_RXD    = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00c;
	localparam int          CTRL_START = 0;
	localparam int          CTRL_KIND  = 1;
	localparam int          CTRL_LEN   = 8;
	localparam logic [1:0]  KIND_RESET = 2'h0;
	localparam logic [1:0]  KIND_IR    = 2'h1;
	localparam logic [1:0]  KIND_DR    = 2'h2;

endpackage

// file: hw/bst_if.sv
// Four-wire scan link joining the test controller and the device port.
`timescale 1ns/1ps
interface bst_if;
	logic tck;
	logic tms_o;
	logic tms_oe;
	logic tdi_o;
	logic tdi_oe;
	logic tdo;
	logic tdo_oe;
	logic tms;
	logic tdi;

	// Internal pull-ups: an undriven select or data input reads high.
	assign tms = tms_oe ? tms_o : 1'b1;
	assign tdi = tdi_oe ? tdi_o : 1'b1;

	modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe);
	modport host (output tck, output tms_o, output tms_oe, output tdi_o, output tdi_oe,
		input tdo, input tdo_oe);
endinterface

// file: hw/bst_tap_dev.sv
// Device end: boundary-scan test access port sampled on the system clock.
`timescale 1ns/1ps
module bst_tap_dev #(
	parameter int         BSR_W       = bst_pkg::BSR_W,
	parameter logic [2:0] INS_EXTEST  = bst_pkg::INS_EXTEST,
	parameter logic [2:0] INS_IDCODE  = bst_pkg::INS_IDCODE,
	parameter logic [2:0] INS_SAMPLEZ = bst_pkg::INS_SAMPLEZ,
	parameter logic [2:0] INS_SAMPLE  = bst_pkg::INS_SAMPLE,
	parameter logic [2:0] INS_BYPASS  = bst_pkg::INS_BYPASS,
	parameter logic [31:0] ID_CODE    = bst_pkg::ID_DEFAULT
) (
	input  wire logic             i_clk_sys,
	input  wire logic             i_arst_n,
	bst_if.dev                    tap,
	input  wire logic [BSR_W-1:0] i_pin_ring,
	input  wire logic             i_q_drive_func,
	output logic                  o_q_drive_en,
	output logic [BSR_W-1:0]      o_bsr_pins,
	output logic                  o_extest
);

	function automatic bst_pkg::bst_state_e tap_next(input bst_pkg::bst_state_e s,
		input logic tms);
		case (s)
			bst_pkg::BST_RESET:     tap_next = tms ? bst_pkg::BST_RESET : bst_pkg::BST_IDLE;
			bst_pkg::BST_IDLE:      tap_next = tms ? bst_pkg::BST_SEL_DR : bst_pkg::BST_IDLE;
			bst_pkg::BST_SEL_DR:    tap_next = tms ? bst_pkg::BST_SEL_IR : bst_pkg::BST_CAPT_DR;
			bst_pkg::BST_CAPT_DR:   tap_next = tms ? bst_pkg::BST_EXIT1_DR : bst_pkg::BST_SHIFT_DR;
			bst_pkg::BST_SHIFT_DR:  tap_next = tms ? bst_pkg::BST_EXIT1_DR : bst_pkg::BST_SHIFT_DR;
			bst_pkg::BST_EXIT1_DR:  tap_next = tms ? bst_pkg::BST_UPDATE_DR : bst_pkg::BST_PAUSE_DR;
			bst_pkg::BST_PAUSE_DR:  tap_next = tms ? bst_pkg::BST_EXIT2_DR : bst_pkg::BST_PAUSE_DR;
			bst_pkg::BST_EXIT2_DR:  tap_next = tms ? bst_pkg::BST_UPDATE_DR : bst_pkg::BST_SHIFT_DR;
			bst_pkg::BST_UPDATE_DR: tap_next = tms ? bst_pkg::BST_SEL_DR : bst_pkg::BST_IDLE;
			bst_pkg::BST_SEL_IR:    tap_next = tms ? bst_pkg::BST_RESET : bst_pkg::BST_CAPT_IR;
			bst_pkg::BST_CAPT_IR:   tap_next = tms ? bst_pkg::BST_EXIT1_IR : bst_pkg::BST_SHIFT_IR;
			bst_pkg::BST_SHIFT_IR:  tap_next = tms ? bst_pkg::BST_EXIT1_IR : bst_pkg::BST_SHIFT_IR;
			bst_pkg::BST_EXIT1_IR:  tap_next = tms ? bst_pkg::BST_UPDATE_IR : bst_pkg::BST_PAUSE_IR;
			bst_pkg::BST_PAUSE_IR:  tap_next = tms ? bst_pkg::BST_EXIT2_IR : bst_pkg::BST_PAUSE_IR;
			bst_pkg::BST_EXIT2_IR:  tap_next = tms ? bst_pkg::BST_UPDATE_IR : bst_pkg::BST_SHIFT_IR;
			bst_pkg::BST_UPDATE_IR: tap_next = tms ? bst_pkg::BST_SEL_DR : bst_pkg::BST_IDLE;
			default:                tap_next = bst_pkg::BST_RESET;
		endcase
	endfunction

	// Pin synchronisers; the third test clock stage only serves edge detection.
	logic [2:0]               tck_s;
	logic [1:0]               tms_s;
	logic [1:0]               tdi_s;
	logic [BSR_W-1:0]         pin_s0;
	logic [BSR_W-1:0]         pin_s1;
	bst_pkg::bst_state_e      state;
	logic [bst_pkg::IR_W-1:0] ir;
	logic [bst_pkg::IR_W-1:0] ir_shift;
	logic                     bypass;
	logic [bst_pkg::ID_W-1:0] id_shift;
	logic [BSR_W-1:0]         bsr_shift;
	logic                     tdo;
	logic                     tdo_oe;

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tck_s  <= 3'h0;
			tms_s  <= 2'h3;
			tdi_s  <= 2'h3;
			pin_s0 <= '0;
			pin_s1 <= '0;
		end else begin
			tck_s  <= {tck_s[1:0], tap.tck};
			tms_s  <= {tms_s[0], tap.tms};
			tdi_s  <= {tdi_s[0], tap.tdi};
			pin_s0 <= i_pin_ring;
			pin_s1 <= pin_s0;
		end
	end

	wire tck_rise = tck_s[1] & ~tck_s[2];
	wire tck_fall = ~tck_s[1] & tck_s[2];
	wire tms      = tms_s[1];
	wire tdi      = tdi_s[1];

	wire sel_bsr = (ir == INS_EXTEST) || (ir == INS_SAMPLE) || (ir == INS_SAMPLEZ);
	wire sel_id  = (ir == INS_IDCODE);
	// Reserved codes fall back to the bypass path so the chain stays one bit long.
	wire sel_byp = !sel_bsr && !sel_id;

	wire in_capt_dr  = tck_rise && (state == bst_pkg::BST_CAPT_DR);
	wire in_shift_dr = tck_rise && (state == bst_pkg::BST_SHIFT_DR);
	wire in_upd_dr   = tck_rise && (state == bst_pkg::BST_UPDATE_DR);
	wire in_reset    = (state == bst_pkg::BST_RESET);

	wire dr_lsb   = sel_bsr ? bsr_shift[0] : (sel_id ? id_shift[0] : bypass);
	wire next_tdo = (state == bst_pkg::BST_SHIFT_IR) ? ir_shift[0] : dr_lsb;
	wire next_oe  = (state == bst_pkg::BST_SHIFT_IR) || (state == bst_pkg::BST_SHIFT_DR);

	// Reset the controller on its own: power-up enters the reset state.
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state <= bst_pkg::BST_RESET;
		end else if (tck_rise) begin
			state <= tap_next(state, tms);
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ir_shift <= bst_pkg::IR_CAPTURE;
		end else if (tck_rise && state == bst_pkg::BST_CAPT_IR) begin
			ir_shift <= bst_pkg::IR_CAPTURE;
		end else if (tck_rise && state == bst_pkg::BST_SHIFT_IR) begin
			ir_shift <= {tdi, ir_shift[bst_pkg::IR_W-1:1]};
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ir <= INS_IDCODE;
		end else if (in_reset) begin
			ir <= INS_IDCODE;
		end else if (tck_rise && state == bst_pkg::BST_UPDATE_IR) begin
			ir <= ir_shift;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bypass <= 1'b0;
		end else if (in_capt_dr && sel_byp) begin
			bypass <= 1'b0;
		end else if (in_shift_dr && sel_byp) begin
			bypass <= tdi;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			id_shift <= '0;
		end else if (in_capt_dr && sel_id) begin
			id_shift <= ID_CODE;
		end else if (in_shift_dr && sel_id) begin
			id_shift <= {tdi, id_shift[bst_pkg::ID_W-1:1]};
		end
	end

	// The pin ring comes from the fast memory domain through two flops per bit; a bit
	// may still be caught mid-transition, so pins must be held steady across a capture.
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bsr_shift <= '0;
		end else if (in_capt_dr && sel_bsr) begin
			bsr_shift <= pin_s1;
		end else if (in_shift_dr && sel_bsr) begin
			bsr_shift <= {tdi, bsr_shift[BSR_W-1:1]};
		end
	end

	// Update stage also holds preload data; the output-enable cell starts low.
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_bsr_pins <= '0;
		end else if (in_reset) begin
			o_bsr_pins[bst_pkg::OE_CELL] <= 1'b0;
		end else if (in_upd_dr && sel_bsr) begin
			o_bsr_pins <= bsr_shift;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tdo    <= 1'b0;
			tdo_oe <= 1'b0;
		end else if (tck_fall) begin
			tdo    <= next_tdo;
			tdo_oe <= next_oe;
		end
	end

	assign tap.tdo    = tdo;
	assign tap.tdo_oe = tdo_oe;

	// Memory side: only the instruction steers it, so a port reset via mode-select
	// never disturbs normal reads and writes while the normal instruction is in force.
	wire ir_extest  = (ir == INS_EXTEST);
	wire ir_samplez = (ir == INS_SAMPLEZ);
	wire next_q_en  = ir_samplez ? 1'b0 :
		(ir_extest ? o_bsr_pins[bst_pkg::OE_CELL] : i_q_drive_func);

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_q_drive_en <= 1'b0;
			o_extest     <= 1'b0;
		end else begin
			o_q_drive_en <= next_q_en;
			o_extest     <= ir_extest;
		end
	end

endmodule

// file: hw/bst_tap_host.sv
// Host end: scan controller that makes the test clock and is steered over APB.
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module bst_tap_host #(
	parameter int HALF_CYC = bst_pkg::TCK_HALF_CYC
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_arst_n,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic             o_pready,
	output logic [31:0]      o_prdata,
	output logic             o_pslverr,
	bst_if.host              tap
);

	typedef enum logic [1:0] {
		BST_H_IDLE = 2'h0,
		BST_H_HDR  = 2'h1,
		BST_H_SHF  = 2'h2,
		BST_H_PST  = 2'h3
	} bst_hstate_e;

	bst_hstate_e hst;
	logic [7:0]  div;
	logic        tck;
	logic        tms;
	logic        tdi;
	logic        drv;
	logic [5:0]  hdr;
	logic [2:0]  hdr_len;
	logic [1:0]  kind;
	logic [4:0]  len_m1;
	logic [4:0]  bitcnt;
	logic [31:0] txd;
	logic [31:0] rxd;
	logic        done;
	logic [1:0]  tdo_s;
	logic        smp;
	logic [4:0]  smp_idx;

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tdo_s <= 2'h0;
		end else begin
			tdo_s <= {tdo_s[0], tap.tdo};
		end
	end

	wire busy     = (hst != BST_H_IDLE) || tck;
	wire acc      = i_psel && i_penable && o_pready;
	wire wr_ctrl  = acc && i_pwrite && (i_paddr == bst_pkg::OFS_CTRL);
	wire wr_txd   = acc && i_pwrite && (i_paddr == bst_pkg::OFS_TXD);
	wire start    = wr_ctrl && i_pwdata[bst_pkg::CTRL_START] && !busy;
	wire [1:0] new_kind = i_pwdata[bst_pkg::CTRL_KIND +: 2];
	wire half     = (div == 8'(HALF_CYC - 1));
	wire rise     = half && !tck && (hst != BST_H_IDLE);
	wire fall     = half && tck;
	wire last_hdr = (bitcnt == 5'(hdr_len - 3'h1));
	wire last_shf = (bitcnt == len_m1);
	wire mapped   = (i_paddr == bst_pkg::OFS_CTRL) || (i_paddr == bst_pkg::OFS_TXD) ||
		(i_paddr == bst_pkg::OFS_RXD) || (i_paddr == bst_pkg::OFS_STATUS);
	wire [31:0] rd_mux = (i_paddr == bst_pkg::OFS_TXD) ? txd :
		(i_paddr == bst_pkg::OFS_RXD) ? rxd :
		(i_paddr == bst_pkg::OFS_STATUS) ? {30'h0, done, busy} : 32'h0;

	// Zero-wait slave: pready rises in the access phase right after setup.
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pready  <= 1'b0;
			o_prdata  <= 32'h0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready  <= i_psel && !i_penable;
			o_prdata  <= (i_psel && !i_penable && !i_pwrite) ? rd_mux : 32'h0;
			o_pslverr <= i_psel && !i_penable && !mapped;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			div <= 8'h0;
		end else begin
			div <= (half || !busy) ? 8'h0 : div + 8'h1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			txd <= 32'h0;
		end else if (wr_txd && !busy) begin
			txd <= i_pwdata;
		end
	end

	// Test clock idles low so the far port never advances between commands.
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tck <= 1'b0;
			drv <= 1'b0;
		end else begin
			drv <= 1'b1;
			if (rise) begin
				tck <= 1'b1;
			end else if (fall) begin
				tck <= 1'b0;
			end
		end
	end

	// Mode-select and data-in change on the falling test clock edge, except that mode-select is set high at command start.
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tms <= 1'b1;
			tdi <= 1'b1;
		end else if (start) begin
			tms <= 1'b1;
		end else if (fall) begin
			case (hst)
				BST_H_HDR: tms <= hdr[bitcnt[2:0]];
				BST_H_SHF: begin
					tms <= last_shf;
					tdi <= txd[bitcnt];
				end
				BST_H_PST: tms <= (bitcnt == 5'h0);
				default:   tms <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			hst     <= BST_H_IDLE;
			bitcnt  <= 5'h0;
			hdr     <= bst_pkg::HDR_RESET;
			hdr_len <= bst_pkg::HDR_RST_LEN;
			kind    <= bst_pkg::KIND_RESET;
			len_m1  <= 5'h0;
			done    <= 1'b0;
		end else if (start) begin
			hst     <= BST_H_HDR;
			bitcnt  <= 5'h0;
			kind    <= new_kind;
			len_m1  <= i_pwdata[bst_pkg::CTRL_LEN +: 5];
			done    <= 1'b0;
			// Reserved instruction codes are the caller's duty to avoid.
			hdr     <= (new_kind == bst_pkg::KIND_IR) ? bst_pkg::HDR_IR :
				(new_kind == bst_pkg::KIND_DR) ? bst_pkg::HDR_DR : bst_pkg::HDR_RESET;
			hdr_len <= (new_kind == bst_pkg::KIND_IR) ? bst_pkg::HDR_IR_LEN :
				(new_kind == bst_pkg::KIND_DR) ? bst_pkg::HDR_DR_LEN : bst_pkg::HDR_RST_LEN;
		end else if (rise) begin
			bitcnt <= bitcnt + 5'h1;
			case (hst)
				BST_H_HDR: if (last_hdr) begin
					bitcnt <= 5'h0;
					hst    <= (kind == bst_pkg::KIND_RESET) ? BST_H_IDLE : BST_H_SHF;
					done   <= (kind == bst_pkg::KIND_RESET);
				end
				BST_H_SHF: if (last_shf) begin
					bitcnt <= 5'h0;
					hst    <= BST_H_PST;
				end
				BST_H_PST: if (bitcnt == 5'h1) begin
					hst  <= BST_H_IDLE;
					done <= 1'b1;
				end
				default: hst <= BST_H_IDLE;
			endcase
		end
	end

	// Output bits arrive least significant first and land at their own index.
	// A bit is stored at the falling edge that ends its bit time: the pin flops here and
	// the far end's edge detector leave it too late for the rising edge itself.
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rxd     <= 32'h0;
			smp     <= 1'b0;
			smp_idx <= 5'h0;
		end else if (start) begin
			rxd <= 32'h0;
			smp <= 1'b0;
		end else if (rise && hst == BST_H_SHF) begin
			smp     <= 1'b1;
			smp_idx <= bitcnt;
		end else if (fall && smp) begin
			rxd[smp_idx] <= tdo_s[1];
			smp          <= 1'b0;
		end
	end

	assign tap.tck    = tck;
	assign tap.tms_o  = tms;
	assign tap.tms_oe = drv;
	assign tap.tdi_o  = tdi;
	assign tap.tdi_oe = drv;

endmodule

// file: test/bst_tap_assertions.sv
// Protocol checker watching the scan link between the two ends.
`timescale 1ns/1ps
module bst_tap_checker (
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic i_tms_oe,
	input wire logic i_tdi,
	input wire logic i_tdi_oe,
	input wire logic i_tdo,
	input wire logic i_tdo_oe
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);

	logic       tck_q;
	logic       tms_at_rise;
	logic [2:0] hi_cnt;
	wire        tck_rise = i_tck && !tck_q;
	wire  [2:0] next_hi_cnt = !i_tms ? 3'h0 : (hi_cnt == 3'h7) ? hi_cnt : hi_cnt + 3'h1;

	// Mode-select is taken on the raw test clock rise, as the device must see it.
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tck_q       <= 1'b0;
			tms_at_rise <= 1'b1;
			hi_cnt      <= 3'h0;
		end else begin
			tck_q <= i_tck;
			if (tck_rise) begin
				tms_at_rise <= i_tms;
				hi_cnt      <= next_hi_cnt;
			end
		end
	end

	sequence s_tck_up;
		$rose(i_tck);
	endsequence

	sequence s_reset_left;
		hi_cnt >= 3'h5 && tck_rise && !i_tms;
	endsequence

	edge_fall_a: assert property (($changed(i_tdo) || $changed(i_tdo_oe)) |-> !i_tck)
		else $error("scan output moved while test clock high");
	hold_high_a: assert property (s_tck_up |=> ($stable(i_tdo) && $stable(i_tdo_oe)) [*3])
		else $error("scan output not held after test clock rise");
	pull_up_a: assert property ((i_tms_oe || i_tms) && (i_tdi_oe || i_tdi))
		else $error("undriven select or data input not high");
	oe_enter_a: assert property ($rose(i_tdo_oe) |-> !tms_at_rise)
		else $error("output driven without entering a shift state");
	oe_exit_a: assert property ($fell(i_tdo_oe) |-> tms_at_rise)
		else $error("output floated without leaving a shift state");
	tap_reset_a: assert property (hi_cnt >= 3'h5 |-> !i_tdo_oe)
		else $error("output driven after five select highs");
	reset_idle_a: assert property (s_reset_left |=> !i_tdo_oe [*8])
		else $error("output driven on leaving reset state");
	power_float_a: assert property ($rose(i_arst_n) |-> (!i_tdo_oe && !i_tck) [*4])
		else $error("port not quiet after power-up");
endmodule

// file: test/test_boundary_scan_tap.sv
// Self-checking bench: host end drives the device end over the scan link.
`timescale 1ns/1ps
module test_boundary_scan_tap;
	logic        clk_sys = 1'b0;
	logic        arst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [63:0] pin_ring = 64'h0;
	logic        q_func = 1'b0;
	logic        q_en;
	logic [63:0] bsr_pins;
	logic        extest;
	int          failures = 0;
	int          num_checks = 0;
	logic [31:0] rd;
	logic [31:0] din;
	logic [31:0] exp_out;
	logic [63:0] bsr_model;
	logic [63:0] junk;
	logic        err;
	logic [2:0]  code;
	logic        bnd;
	logic [2:0]  codes [6] = '{bst_pkg::INS_IDCODE, bst_pkg::INS_SAMPLE, bst_pkg::INS_SAMPLEZ,
		bst_pkg::INS_BYPASS, bst_pkg::INS_SAMPLE, bst_pkg::INS_EXTEST};

	always #4 clk_sys = ~clk_sys;

	bst_if link ();
	bst_tap_host bst_tap_host_i (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .tap(link));
	bst_tap_dev bst_tap_dev_i (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .tap(link),
		.i_pin_ring(pin_ring), .i_q_drive_func(q_func), .o_q_drive_en(q_en),
		.o_bsr_pins(bsr_pins), .o_extest(extest));
	bst_tap_checker checker_i (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_tck(link.tck),
		.i_tms(link.tms), .i_tms_oe(link.tms_oe), .i_tdi(link.tdi), .i_tdi_oe(link.tdi_oe),
		.i_tdo(link.tdo), .i_tdo_oe(link.tdo_oe));

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Called just after a rising edge; returns one edge after the request is released.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1 && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 100) begin
			failures++;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic scan(input logic [1:0] kind, input int len, input logic [31:0] d,
		output logic [31:0] r);
		logic [31:0] st;
		logic        e;
		logic [4:0]  l;
		int          k;
		k = 0;
		l = 5'(len - 1);
		apb(1'b1, bst_pkg::OFS_TXD, d, st, e);
		apb(1'b1, bst_pkg::OFS_CTRL, {19'h0, l, 5'h0, kind, 1'b1}, st, e);
		st = 32'h0;
		while (st[1] !== 1'b1 && k < 2000) begin
			apb(1'b0, bst_pkg::OFS_STATUS, 32'h0, st, e);
			k++;
		end
		if (k >= 2000) begin
			failures++;
		end
		apb(1'b0, bst_pkg::OFS_RXD, 32'h0, r, e);
	endtask

	// Reference shift chain: capture value enters, first bit out is the low end.
	task automatic model(input logic [63:0] cap, input int len, input logic [31:0] d,
		input int n, output logic [31:0] o, output logic [63:0] after);
		bit q[$];
		for (int i = 0; i < len; i++) q.push_back(cap[i]);
		o = 32'h0;
		for (int i = 0; i < n; i++) begin
			o[i] = q.pop_front();
			q.push_back(d[i]);
		end
		after = 64'h0;
		for (int i = 0; i < len; i++) after[i] = q[i];
	endtask

	initial begin
		repeat (50000) @(posedge clk_sys);
		failures++;
		conclude();
	end

	initial begin
		void'($urandom(82994));
		repeat (20) @(posedge clk_sys);
		check("tms pulled up", link.tms, 1'b1);
		check("tdi pulled up", link.tdi, 1'b1);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		@(posedge clk_sys);
		check("tdo_oe", link.tdo_oe, 1'b0);
		check("extest", extest, 1'b0);
		scan(bst_pkg::KIND_RESET, 1, 32'h0, rd);
		din = $urandom;
		model(bst_pkg::ID_DEFAULT, 32, din, 32, exp_out, junk);
		scan(bst_pkg::KIND_DR, 32, din, rd);
		check("idcode", rd, exp_out);
		$display("test power-up done");
		foreach (codes[i]) begin
			code = codes[i];
			q_func <= 1'($urandom);
			pin_ring <= {$urandom, $urandom};
			scan(bst_pkg::KIND_IR, 3, {29'h0, code}, rd);
			check("ir capture", rd[1:0], bst_pkg::IR_CAPTURE[1:0]);
			check("extest flag", extest, code === bst_pkg::INS_EXTEST);
			din = $urandom;
			bnd = code inside {bst_pkg::INS_EXTEST, bst_pkg::INS_SAMPLE, bst_pkg::INS_SAMPLEZ};
			if (code === bst_pkg::INS_IDCODE) begin
				model(bst_pkg::ID_DEFAULT, 32, din, 32, exp_out, junk);
			end else if (bnd) begin
				model(pin_ring, 64, din, 32, exp_out, bsr_model);
			end else begin
				model(64'h0, 1, din, 32, exp_out, junk);
			end
			scan(bst_pkg::KIND_DR, 32, din, rd);
			check("scan out", rd, exp_out);
			if (code === bst_pkg::INS_SAMPLE || code === bst_pkg::INS_EXTEST) begin
				check("update stage", bsr_pins, bsr_model);
			end
			check("drive", q_en, (code === bst_pkg::INS_SAMPLEZ) ? 1'b0 :
				(code === bst_pkg::INS_EXTEST) ? bsr_model[47] : q_func);
			$display("test instruction %h done", code);
		end
		scan(bst_pkg::KIND_RESET, 1, 32'h0, rd);
		check("extest after reset", extest, 1'b0);
		check("drive after reset", q_en, q_func);
		din = $urandom;
		model(bst_pkg::ID_DEFAULT, 32, din, 32, exp_out, junk);
		scan(bst_pkg::KIND_DR, 32, din, rd);
		check("idcode after reset", rd, exp_out);
		$display("test port reset done");
		apb(1'b0, 12'h010, 32'h0, rd, err);
		check("unmapped error", err, 1'b1);
		check("unmapped data", rd, 32'h0);
		$display("test unmapped access done");
		conclude();
	end
endmodule
